/* pkg/pwm_pkg.sv */
// Register map, field positions, reset values and bus carrier of the PWM timer
package pwm_pkg;
  // Functional notes
  // - Four independent 8-bit PWM waveforms, one per port pin as alternate function.
  // - Every channel owns its own 8-bit counter, period and duty register.
  // - Period/duty writes while enabled wait in a buffer until rollover or disable.
  // - Counter write after period/duty write loads the new values at once.
  // - Counter matching the effective period ends the output cycle.
  // - Counter matching the effective duty flips the output mid cycle.
  // - Bit 7 joins channels 3 and 4, bit 6 joins channels 1 and 2.
  // - A joined pair uses the clock of its low channel, 2 or 4.
  // - In 16-bit mode pins of channels 1 and 3 are released.
  // - Joined 3-4: channel 3 is the upper byte, output on channel 4 pin.
  // - Joined 1-2: channel 1 is the upper byte, output on channel 2 pin.
  // - Upper counter byte read latches lower byte for one cycle.
  // - 16-bit mode: low counter byte write clears all, upper write ignored.
  // - Clock A is bus clock divided by 1, 2, 4 or 8.
  // - Clock B is bus clock divided by two to the field value, up to 128.
  // - 8-bit counter on clock A resets on scale match and toggles clock S.
  // - Clock S ranges from clock A over 2 down to clock A over 512.
  // - Each channel picks one of two clocks: scaled or its own prescaled.
  // - Bit 3 of the clock-select register is absent and reads zero.
  // - Clock S is clock A over twice the scale value, zero meaning 256.
  // - Select bit set picks clock S, else A for channels 1-2, B for 3-4.
  // - Start level is high with polarity set, low when clear; flips at duty.
  // - Enable forces the pin to output and gates the clock only on a clock edge.

  // ----------------------------
  // Register offsets
  // ----------------------------
  localparam logic [7:0] A_CLK = 8'h60;
  localparam logic [7:0] A_POL = 8'h61;
  localparam logic [7:0] A_SCL = 8'h62;
  localparam logic [7:0] A_EN  = 8'h63;
  localparam logic [7:0] A_CNT = 8'h64;
  localparam logic [7:0] A_PER = 8'h68;
  localparam logic [7:0] A_DTY = 8'h6c;

  // ----------------------------
  // Field positions and masks
  // ----------------------------
  localparam int J34_BIT = 7;
  localparam int J12_BIT = 6;
  localparam int CKA_LSB = 4;
  localparam int CKB_LSB = 0;
  localparam int SELS_LSB = 4;
  localparam logic [7:0] CLK_MASK = 8'hf7;
  localparam logic [7:0] EN_MASK  = 8'h0f;

  // ----------------------------
  // Reset values
  // ----------------------------
  localparam logic [7:0] RST_REG = 8'h00;
  localparam logic [7:0] RST_PD  = 8'hff;

  // Register bus request
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } bus_req_t;
endpackage : pwm_pkg

/* rtl/four_channel_pwm_timer.sv */
// Four-channel PWM timer with clock prescalers, scaled clock and pair joining
//
// Added by the designer: the strobed register port.
`timescale 1ns/100ps
module four_channel_pwm_timer (
  input  wire logic       i_mclk,
  input  wire logic       i_rst,
  input  wire logic [7:0] i_addr,
  input  wire logic [7:0] i_wdata,
  input  wire logic       i_wr,
  input  wire logic       i_rd,
  output logic      [7:0] o_rdata,
  output logic      [3:0] o_wave_out,
  output logic      [3:0] o_wave_out_oe
);

  // ----------------------------
  // Functions
  // ----------------------------

  // One-hot select of a group of four byte registers
  function automatic logic [3:0] group_dec(input logic [7:0] a,
                                           input logic [7:0] base);
    group_dec = 4'h0;
    if (a[7:2] == base[7:2]) begin
      group_dec[a[1:0]] = 1'b1;
    end
  endfunction : group_dec

  // Tick once every two-to-the-code bus cycles
  function automatic logic div_tick(input logic [6:0] pre,
                                    input logic [2:0] code);
    logic [7:0] mask;
    mask = (8'h01 << code) - 8'h01;
    div_tick = &(pre | ~mask[6:0]);
  endfunction : div_tick

  // ----------------------------
  // State
  // ----------------------------
  pwm_pkg::bus_req_t req;
  logic [7:0] clk_q;
  logic [7:0] pol_q;
  logic [7:0] scl_q;
  logic [7:0] en_q;
  logic [7:0] cnt_q  [4];
  logic [7:0] cnt_d  [4];
  logic [7:0] per_q  [4];
  logic [7:0] dty_q  [4];
  logic [7:0] pbuf_q [4];
  logic [7:0] dbuf_q [4];
  logic [3:0] run_q;
  logic [3:0] run_d;
  logic [3:0] lvl_q;
  logic [3:0] lvl_d;
  logic [3:0] wave_d;
  logic [3:0] oe_d;
  logic [6:0] pre_q;
  logic [7:0] scnt_q;
  logic       stog_q;
  logic [7:0] snap_q;
  logic [3:0] snap_v_q;
  logic [7:0] rdata_q;
  logic [3:0] wave_q;
  logic [3:0] oe_q;

  // ----------------------------
  // Register bus decode
  // ----------------------------

  // Strobes come from logic on this clock, so no synchroniser
  assign req = {i_addr, i_wdata, i_wr, i_rd};

  wire       wr_clk = req.wr && (req.addr == pwm_pkg::A_CLK);
  wire       wr_pol = req.wr && (req.addr == pwm_pkg::A_POL);
  wire       wr_scl = req.wr && (req.addr == pwm_pkg::A_SCL);
  wire       wr_en  = req.wr && (req.addr == pwm_pkg::A_EN);
  wire [3:0] sel_cnt = group_dec(req.addr, pwm_pkg::A_CNT);
  wire [3:0] sel_per = group_dec(req.addr, pwm_pkg::A_PER);
  wire [3:0] sel_dty = group_dec(req.addr, pwm_pkg::A_DTY);
  wire [3:0] cnt_wr  = sel_cnt & {4{req.wr}};
  wire [3:0] per_wr  = sel_per & {4{req.wr}};
  wire [3:0] dty_wr  = sel_dty & {4{req.wr}};

  // ----------------------------
  // Configuration fields
  // ----------------------------

  // Pair 1-2 is bit 0, pair 3-4 is bit 1
  wire [1:0] join_w = {clk_q[pwm_pkg::J34_BIT],
                       clk_q[pwm_pkg::J12_BIT]};
  wire [1:0] cka    = clk_q[pwm_pkg::CKA_LSB +: 2];
  wire [2:0] ckb    = clk_q[pwm_pkg::CKB_LSB +: 3];

  // ----------------------------
  // Clock section
  // ----------------------------

  // Clocks A, B and S are one-cycle ticks off a shared prescaler,
  // which keeps the whole block in one domain
  wire tick_a = div_tick(pre_q, {1'b0, cka});
  wire tick_b = div_tick(pre_q, ckb);

  // Scale value zero wraps the 8-bit compare, acting as 256
  wire scl_hit = tick_a && (8'(scnt_q + 8'h01) == scl_q);
  wire tick_s  = scl_hit && stog_q;

  // Prescaler and scaled-clock counter
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      pre_q  <= 7'h00;
      scnt_q <= 8'h00;
      stog_q <= 1'b0;
    end else begin
      pre_q <= pre_q + 7'h01;
      if (scl_hit) begin
        scnt_q <= 8'h00;
        stog_q <= ~stog_q;
      end else if (tick_a) begin
        scnt_q <= scnt_q + 8'h01;
      end
    end
  end

  // ----------------------------
  // Channel engine
  // ----------------------------
  logic [3:0] raw_tick;
  logic [3:0] tick;
  logic [3:0] wrap;
  logic [3:0] hit;
  logic [3:0] load;
  logic [3:0] cwr;
  logic [3:0] hi_ch;

  // A joined pair is run by its low channel; both bytes then compute
  // the same 16-bit step and each keeps its own byte of it
  always_comb begin
    int lo;
    int hi;
    int src;
    logic cat;
    logic zd;
    logic [15:0] c16;
    logic [15:0] p16;
    logic [15:0] d16;
    logic [15:0] nxt;
    lo  = 0;
    hi  = 0;
    src = 0;
    cat = 1'b0;
    zd  = 1'b0;
    c16 = 16'h0000;
    p16 = 16'h0000;
    d16 = 16'h0000;
    nxt = 16'h0000;
    for (int i = 0; i < 4; i++) begin
      raw_tick[i] = pol_q[pwm_pkg::SELS_LSB + i] ? tick_s
                  : ((i < 2) ? tick_a : tick_b);
      run_d[i]    = raw_tick[i] ? en_q[i] : run_q[i];
    end
    for (int i = 0; i < 4; i++) begin
      lo  = i | 1;
      hi  = i & 2;
      cat = join_w[i / 2];
      src = cat ? lo : i;
      hi_ch[i] = cat && (i == hi);
      tick[i]  = raw_tick[src] && run_q[src];
      if (cat) begin
        c16 = {cnt_q[hi], cnt_q[lo]};
        p16 = {pbuf_q[hi], pbuf_q[lo]};
        d16 = {dbuf_q[hi], dbuf_q[lo]};
        zd  = ({dty_q[hi], dty_q[lo]} == 16'h0000);
      end else begin
        c16 = {8'h00, cnt_q[i]};
        p16 = {8'h00, pbuf_q[i]};
        d16 = {8'h00, dbuf_q[i]};
        zd  = (dty_q[i] == 8'h00);
      end
      nxt     = c16 + 16'h0001;
      wrap[i] = (nxt == p16);
      hit[i]  = (nxt == d16);
      // Upper-byte counter writes are dropped when joined
      cwr[i]  = cat ? cnt_wr[lo] : cnt_wr[i];
      load[i] = !run_q[src] || (tick[i] && wrap[i])
              || cwr[i];
      if (cwr[i] || (tick[i] && wrap[i])) begin
        cnt_d[i] = 8'h00;
      end else if (tick[i]) begin
        cnt_d[i] = hi_ch[i] ? nxt[15:8] : nxt[7:0];
      end else begin
        cnt_d[i] = cnt_q[i];
      end
      // Zero duty keeps the output in its after-duty state
      if (load[i]) begin
        lvl_d[i] = zd;
      end else if (tick[i] && hit[i]) begin
        lvl_d[i] = 1'b1;
      end else begin
        lvl_d[i] = lvl_q[i];
      end
      wave_d[i] = hi_ch[i] ? 1'b0
                : (lvl_d[i] ? ~pol_q[src] : pol_q[src]);
      oe_d[i]   = !hi_ch[i] && en_q[i];
    end
  end

  // ----------------------------
  // Register file
  // ----------------------------

  // Software-visible registers; reads return the last value written, with the bits cleared by CLK_MASK and EN_MASK reading zero
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      clk_q <= pwm_pkg::RST_REG;
      pol_q <= pwm_pkg::RST_REG;
      scl_q <= pwm_pkg::RST_REG;
      en_q  <= pwm_pkg::RST_REG;
    end else begin
      if (wr_clk) clk_q <= req.wdata & pwm_pkg::CLK_MASK;
      if (wr_pol) pol_q <= req.wdata;
      if (wr_scl) scl_q <= req.wdata;
      if (wr_en)  en_q  <= req.wdata & pwm_pkg::EN_MASK;
    end
  end

  // Per-channel counters, registers and buffers
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      for (int i = 0; i < 4; i++) begin
        cnt_q[i]  <= pwm_pkg::RST_REG;
        per_q[i]  <= pwm_pkg::RST_PD;
        dty_q[i]  <= pwm_pkg::RST_PD;
        pbuf_q[i] <= pwm_pkg::RST_PD;
        dbuf_q[i] <= pwm_pkg::RST_PD;
      end
    end else begin
      for (int i = 0; i < 4; i++) begin
        cnt_q[i] <= cnt_d[i];
        if (per_wr[i]) per_q[i] <= req.wdata;
        if (dty_wr[i]) dty_q[i] <= req.wdata;
        if (load[i]) begin
          pbuf_q[i] <= per_q[i];
          dbuf_q[i] <= dty_q[i];
        end
      end
    end
  end

  // Output and clock-gate flops
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      run_q  <= 4'h0;
      lvl_q  <= 4'h0;
      wave_q <= 4'h0;
      oe_q   <= 4'h0;
    end else begin
      run_q  <= run_d;
      lvl_q  <= lvl_d;
      wave_q <= wave_d;
      oe_q   <= oe_d;
    end
  end

  // ----------------------------
  // Read path
  // ----------------------------

  // Upper counter read freezes the low byte for the next cycle only,
  // so a back-to-back low read sees a coherent 16-bit count
  wire take12 = req.rd && sel_cnt[0] && join_w[0];
  wire take34 = req.rd && sel_cnt[2] && join_w[1];

  logic [7:0] rd_val;

  // Read mux; unmapped addresses read zero
  always_comb begin
    rd_val = 8'h00;
    if (req.addr == pwm_pkg::A_CLK) rd_val = clk_q;
    if (req.addr == pwm_pkg::A_POL) rd_val = pol_q;
    if (req.addr == pwm_pkg::A_SCL) rd_val = scl_q;
    if (req.addr == pwm_pkg::A_EN)  rd_val = en_q;
    for (int i = 0; i < 4; i++) begin
      if (sel_cnt[i]) rd_val = snap_v_q[i] ? snap_q : cnt_q[i];
      if (sel_per[i]) rd_val = per_q[i];
      if (sel_dty[i]) rd_val = dty_q[i];
    end
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      rdata_q  <= 8'h00;
      snap_q   <= 8'h00;
      snap_v_q <= 4'h0;
    end else begin
      rdata_q  <= req.rd ? rd_val : 8'h00;
      snap_q   <= take34 ? cnt_q[3] : cnt_q[1];
      snap_v_q <= {take34, 1'b0, take12, 1'b0};
    end
  end

  assign o_rdata       = rdata_q;
  assign o_wave_out    = wave_q;
  assign o_wave_out_oe = oe_q;

  // ----------------------------
  // Assertions
  // ----------------------------
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (i_rst);

  property p_bit3_zero;
    req.rd && (req.addr == pwm_pkg::A_CLK) |=> !o_rdata[3];
  endproperty
  a_bit3_zero: assert property (p_bit3_zero)
    else $error("clock select bit 3 read back set");

  property p_lo_wr_clr;
    cnt_wr[3] && join_w[1] |=> (cnt_q[3] == 8'h00) && (cnt_q[2] == 8'h00);
  endproperty
  a_lo_wr_clr: assert property (p_lo_wr_clr)
    else $error("low counter write did not clear joined counter");

  property p_hi_wr_ign;
    cnt_wr[2] && join_w[1] && !tick[2] && !cnt_wr[3] |=> $stable(cnt_q[2]);
  endproperty
  a_hi_wr_ign: assert property (p_hi_wr_ign)
    else $error("upper counter write changed joined counter");

  property p_wrap_clr;
    tick[1] && wrap[1] && !cwr[1] |=> (cnt_q[1] == 8'h00)
      && (pbuf_q[1] == $past(per_q[1]));
  endproperty
  a_wrap_clr: assert property (p_wrap_clr)
    else $error("period match did not clear and reload");

  property p_duty_flip;
    tick[3] && hit[3] && !load[3] |=> lvl_q[3];
  endproperty
  a_duty_flip: assert property (p_duty_flip)
    else $error("duty match did not flip output");

  property p_polarity;
    !$past(join_w[0]) |-> o_wave_out[0] == (lvl_q[0] ^ $past(pol_q[0]));
  endproperty
  a_polarity: assert property (p_polarity)
    else $error("output level does not follow polarity");

  property p_hi_pin_free;
    join_w[0] |=> !o_wave_out_oe[0] && !o_wave_out[0];
  endproperty
  a_hi_pin_free: assert property (p_hi_pin_free)
    else $error("channel 1 pin driven in 16-bit mode");

  property p_en_oe;
    1'b1 |=> o_wave_out_oe[3] == $past(en_q[3]);
  endproperty
  a_en_oe: assert property (p_en_oe)
    else $error("enable does not force channel 4 pin to output");

  property p_buf_hold;
    run_q[0] && !join_w[0] && !(tick[0] && wrap[0]) && !cwr[0]
      |=> $stable(pbuf_q[0]) && $stable(dbuf_q[0]);
  endproperty
  a_buf_hold: assert property (p_buf_hold)
    else $error("buffer changed while channel running");

  property p_clka_div8;
    tick_a && (cka == 2'h3) |-> pre_q[2:0] == 3'h7;
  endproperty
  a_clka_div8: assert property (p_clka_div8)
    else $error("clock A not divided by 8");

  property p_clkb_div128;
    tick_b && (ckb == 3'h7) |-> pre_q == 7'h7f;
  endproperty
  a_clkb_div128: assert property (p_clkb_div128)
    else $error("clock B not divided by 128");

endmodule : four_channel_pwm_timer

/* testbench/pwm_pin_loads.sv */
// Port pin loads with pull-ups that count the cycles each pin spends high
`timescale 1ns/100ps
module pwm_pin_loads (
  input  wire logic             i_mclk,
  input  wire logic             i_clr,
  input  wire logic [3:0]       i_wave,
  input  wire logic [3:0]       i_oe,
  output logic      [3:0][15:0] o_high_cnt
);
  logic [3:0] pin;

  // A released pin floats up to the pull-up level, never to the last driven value
  assign pin = (i_oe & i_wave) | ~i_oe;

  // High-time counters; a window length that is a whole number of periods makes the count phase-free
  always_ff @(posedge i_mclk) begin
    for (int k = 0; k < 4; k++) begin
      o_high_cnt[k] <= i_clr ? 16'h0000 : o_high_cnt[k] + {15'h0000, pin[k]};
    end
  end
endmodule : pwm_pin_loads

/* testbench/four_channel_pwm_timer_bench.sv */
// Self-checking bench for the four-channel PWM timer
`timescale 1ns/100ps
module four_channel_pwm_timer_bench;
  logic             i_mclk;
  logic             i_rst;
  logic             i_wr;
  logic             i_rd;
  logic             clr;
  logic [7:0]       i_addr;
  logic [7:0]       i_wdata;
  logic [7:0]       o_rdata;
  logic [7:0]       d0;
  logic [7:0]       d1;
  logic [7:0]       d2;
  logic [3:0]       o_wave_out;
  logic [3:0]       o_wave_out_oe;
  logic [3:0][15:0] high_cnt;
  int               errors;
  int               compares;
  int               sp;
  int               scl [3] = '{1, 3, 0};

  four_channel_pwm_timer dut (.i_mclk(i_mclk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_wave_out(o_wave_out), .o_wave_out_oe(o_wave_out_oe));
  pwm_pin_loads loads (.i_mclk(i_mclk), .i_clr(clr), .i_wave(o_wave_out), .i_oe(o_wave_out_oe),
    .o_high_cnt(high_cnt));

  // Bus clock
  always #5 i_mclk = ~i_mclk;

  // ----------------------------
  // Verdict and comparisons
  // ----------------------------
  task automatic end_sim;
    $display("errors=%0d compares=%0d", errors, compares);
    if (errors == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : end_sim

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk8

  task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk16

  // ----------------------------
  // Register bus cycles
  // ----------------------------
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_mclk);
    i_wr    <= 1'b1;
    i_addr  <= a;
    i_wdata <= d;
    @(posedge i_mclk);
    i_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    @(posedge i_mclk);
    i_rd   <= 1'b1;
    i_addr <= a;
    @(posedge i_mclk);
    i_rd <= 1'b0;
    #1 d0 = o_rdata;
  endtask : rd

  // Three reads with no gap; each answer is caught in the cycle after its strobe
  task automatic rd3(input logic [7:0] a0, input logic [7:0] a1, input logic [7:0] a2);
    @(posedge i_mclk);
    i_rd   <= 1'b1;
    i_addr <= a0;
    @(posedge i_mclk);
    i_addr <= a1;
    #1 d0 = o_rdata;
    @(posedge i_mclk);
    i_addr <= a2;
    #1 d1 = o_rdata;
    @(posedge i_mclk);
    i_rd <= 1'b0;
    #1 d2 = o_rdata;
  endtask : rd3

  // Period, duty, then a counter write to force both into effect at once
  task automatic setup(input int ch, input logic [7:0] per, input logic [7:0] dty);
    wr(pwm_pkg::A_PER + 8'(ch), per);
    wr(pwm_pkg::A_DTY + 8'(ch), dty);
    wr(pwm_pkg::A_CNT + 8'(ch), 8'h00);
  endtask : setup

  // Let the wave settle for one window, then count high cycles over the next
  task automatic measure(input int ch, input int w, input logic [15:0] exp);
    repeat (w) @(posedge i_mclk);
    @(posedge i_mclk);
    clr <= 1'b1;
    @(posedge i_mclk);
    clr <= 1'b0;
    repeat (w) @(posedge i_mclk);
    #1 chk16(high_cnt[ch], exp);
  endtask : measure

  // ----------------------------
  // Watchdog
  // ----------------------------
  initial begin
    #600000;
    errors++;
    end_sim();
  end

  // ----------------------------
  // Test sequence
  // ----------------------------
  initial begin
    i_mclk = 1'b0; i_rst = 1'b1; i_wr = 1'b0; i_rd = 1'b0;
    i_addr = 8'h00; i_wdata = 8'h00; clr = 1'b0; errors = 0; compares = 0;
    repeat (6) @(posedge i_mclk);
    i_rst <= 1'b0;
    // Reset values of the whole map, then an unmapped place
    for (int a = 0; a < 16; a++) begin
      rd(pwm_pkg::A_CLK + 8'(a));
      chk8(d0, (a < 8) ? 8'h00 : 8'hff);
    end
    wr(8'h70, 8'hff);
    rd(8'h70);
    chk8(d0, 8'h00);
    wr(pwm_pkg::A_CLK, 8'hff);
    rd(pwm_pkg::A_CLK);
    chk8(d0, 8'hf7);
    wr(pwm_pkg::A_EN, 8'hff);
    rd(pwm_pkg::A_EN);
    chk8(d0, 8'h0f);
    // Both pairs are still joined here, so the upper-channel pins stay released
    chk8({4'h0, o_wave_out_oe}, 8'h0a);
    wr(pwm_pkg::A_CLK, 8'h00);
    // Channel 1 on clock A, starting high, a quarter high for every divider code
    wr(pwm_pkg::A_POL, 8'h01);
    wr(pwm_pkg::A_EN, 8'h01);
    for (int c = 0; c < 4; c++) begin
      wr(pwm_pkg::A_CLK, 8'(c << 4));
      setup(0, 8'h04, 8'h01);
      measure(0, 32 << c, 16'(8 << c));
    end
    // Channel 3 on clock B, starting low, three quarters high for every code
    wr(pwm_pkg::A_POL, 8'h00);
    wr(pwm_pkg::A_EN, 8'h04);
    for (int c = 0; c < 8; c++) begin
      wr(pwm_pkg::A_CLK, 8'(c));
      setup(2, 8'h04, 8'h01);
      measure(2, 16 << c, 16'(12 << c));
    end
    // Channel 2 on the scaled clock; a scale of zero counts as 256
    wr(pwm_pkg::A_CLK, 8'h00);
    wr(pwm_pkg::A_POL, 8'h22);
    wr(pwm_pkg::A_EN, 8'h02);
    foreach (scl[i]) begin
      sp = (scl[i] == 0) ? 512 : 2 * scl[i];
      wr(pwm_pkg::A_SCL, 8'(scl[i]));
      // A scale below the running count only matches after a full wrap of the count
      repeat (256) @(posedge i_mclk);
      setup(1, 8'h02, 8'h01);
      measure(1, 8 * sp, 16'(4 * sp));
    end
    // A duty written mid-cycle waits for rollover; a counter write forces it in
    wr(pwm_pkg::A_POL, 8'h01);
    wr(pwm_pkg::A_EN, 8'h01);
    setup(0, 8'd200, 8'd100);
    repeat (5) @(posedge i_mclk);
    wr(pwm_pkg::A_DTY, 8'd30);
    repeat (40) @(posedge i_mclk);
    #1 chk8({7'h00, o_wave_out[0]}, 8'h01);
    wr(pwm_pkg::A_CNT, 8'h00);
    repeat (60) @(posedge i_mclk);
    #1 chk8({7'h00, o_wave_out[0]}, 8'h00);
    // Joined pairs: 258-tick period, 129 high, upper channel set to the slow scaled clock
    for (int p = 0; p < 2; p++) begin
      wr(pwm_pkg::A_CLK, 8'(8'h40 << p));
      wr(pwm_pkg::A_POL, 8'(8'h12 << (2 * p)));
      wr(pwm_pkg::A_EN, 8'(8'h03 << (2 * p)));
      wr(pwm_pkg::A_PER + 8'(2 * p), 8'h01);
      wr(pwm_pkg::A_DTY + 8'(2 * p), 8'h00);
      setup(2 * p + 1, 8'h02, 8'h81);
      measure(2 * p + 1, 516, 16'd258);
      chk16(high_cnt[2 * p], 16'd516);
      chk8({4'h0, o_wave_out_oe}, 8'(8'h02 << (2 * p)));
      // Let the count run on to 256 so the low write must also clear a set upper byte
      repeat (253) @(posedge i_mclk);
      wr(pwm_pkg::A_CNT + 8'(2 * p + 1), 8'h00);
      rd3(pwm_pkg::A_CNT + 8'(2 * p + 1), pwm_pkg::A_CNT + 8'(2 * p), pwm_pkg::A_CNT + 8'(2 * p + 1));
      chk8(d0, 8'h01);
      chk8(d1, 8'h00);
      chk8(d2, d0 + 8'h01);
      // Stop the pair, then an upper counter write must leave the count alone
      wr(pwm_pkg::A_EN, 8'h00);
      wr(pwm_pkg::A_CNT + 8'(2 * p), 8'h5a);
      rd(pwm_pkg::A_CNT + 8'(2 * p));
      chk8(d0, 8'h00);
    end
    end_sim();
  end
endmodule : four_channel_pwm_timer_bench
